// ===== rtl/sar_adc_conv_serial_ctrl.sv
// Converter control and serial read port of an 8-bit sampling converter
//
// How it works
// - Falling conv_start_n ends tracking, holds sample and starts a 4 us conversion.
// - At conversion end, load result and sample conv_start_n to choose power state.
// - conv_start_n high at conversion end keeps the converter powered.
// - conv_start_n low at conversion end latches result then powers down.
// - Rising conv_start_n while powered down wakes the converter in 1.5 us.
// - Power-down mode conversion takes 4 us, about 5.5 us from wake-up.
// - Early falling edge during power-up waits out power-up, then converts.
// - Rising conv_start_n enables the serial port in both modes.
// - Read before conversion end gives previous result; after gives current.
// - A read in progress at conversion end delays the new result load.
// - Serial output keeps working while the converter is powered down.
// - Each rising conv_start_n clears the serial bit counter.
// - After eight bits, serial clock edges are ignored until re-armed.
// - First bit driven on first serial clock rise after conv_start_n rise.
// - Data output returns to high impedance on the eighth serial clock fall.
// - No data is shifted until a conv_start_n rising edge is seen.
// - Serial port works with continuous or burst serial clock.
// - Result is straight unsigned binary, one step per reference over 256.
// - After reset the converter starts powered down.
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
module sar_adc_conv_serial_ctrl
   import adc_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic conv_start_n,
   input wire logic sclk,
   input wire logic [`RES_W-1:0] sample_code,
   output logic dout_o,
   output logic dout_oe,
   output logic powered,
   output logic tracking,
   output logic conv_busy,
   output logic sample_hold
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic cs_level;
   logic cs_rise;
   logic cs_fall;
   logic sck_rise;
   logic sck_fall;

   pin_sync cs_sync (
      .clk(clk),
      .rst(rst),
      .din(conv_start_n),
      .level(cs_level),
      .rise(cs_rise),
      .fall(cs_fall)
   );

   // Serial clock edges found by sampling; the link clock may stop freely
   pin_sync sck_sync (
      .clk(clk),
      .rst(rst),
      .din(sclk),
      .level(),
      .rise(sck_rise),
      .fall(sck_fall)
   );

   // ---------------------------------------------------------------
   // Power and conversion sequencing
   // ---------------------------------------------------------------
   conv_state_t state_r;
   logic [`CNT_W-1:0] tmr_r;
   logic start_pend_r;
   logic conv_done;
   logic [`RES_W-1:0] conv_code_r;
   logic new_pend_r;

   assign conv_done = (state_r == CONVERT) && (tmr_r == `CNT_W'(`CONV_CYC - 1));

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= PWR_DOWN;
         tmr_r <= '0;
         start_pend_r <= 1'b0;
      end else begin
         case (state_r)
            PWR_DOWN: begin
               if (cs_rise) begin
                  state_r <= PWR_UP;
                  tmr_r <= '0;
                  start_pend_r <= 1'b0;
               end
            end
            PWR_UP: begin
               if (cs_fall) begin
                  start_pend_r <= 1'b1;
               end
               if (tmr_r == `CNT_W'(`PWRUP_CYC - 1)) begin
                  tmr_r <= '0;
                  // Early falling edge: conversion starts once power-up is timed out
                  state_r <= (start_pend_r || cs_fall) ? CONVERT : IDLE;
                  start_pend_r <= 1'b0;
               end else begin
                  tmr_r <= tmr_r + `CNT_W'(1);
               end
            end
            IDLE: begin
               if (cs_fall) begin
                  state_r <= CONVERT;
                  tmr_r <= '0;
               end
            end
            CONVERT: begin
               if (conv_done) begin
                  tmr_r <= '0;
                  // Level at the end decides the mode
                  state_r <= cs_level ? IDLE : PWR_DOWN;
               end else begin
                  tmr_r <= tmr_r + `CNT_W'(1);
               end
            end
            default: state_r <= PWR_DOWN;
         endcase
      end
   end

   // Code is taken straight binary from the front end at hold time
   always_ff @(posedge clk) begin
      if (rst) begin
         conv_code_r <= '0;
      end else if ((state_r == IDLE && cs_fall) ||
                   (state_r == PWR_UP && tmr_r == `CNT_W'(`PWRUP_CYC - 1) &&
                    (start_pend_r || cs_fall))) begin
         conv_code_r <= sample_code;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         powered <= 1'b0;
         tracking <= 1'b0;
         conv_busy <= 1'b0;
         sample_hold <= 1'b0;
      end else begin
         powered <= (state_r != PWR_DOWN);
         tracking <= (state_r == IDLE);
         conv_busy <= (state_r == CONVERT);
         sample_hold <= (state_r == CONVERT);
      end
   end

   // ---------------------------------------------------------------
   // Serial read port
   // ---------------------------------------------------------------
   logic armed_r;
   logic [3:0] bit_cnt_r;
   logic [`RES_W-1:0] shift_r;
   logic [`RES_W-1:0] out_reg_r;
   logic reading;
   logic load_now;

   // A read is in progress between its first bit and the eighth falling edge
   assign reading = armed_r && (bit_cnt_r != `BIT_CNT_ZERO);
   assign load_now = new_pend_r && !reading;

   always_ff @(posedge clk) begin
      if (rst) begin
         new_pend_r <= 1'b0;
      end else if (conv_done) begin
         new_pend_r <= 1'b1;
      end else if (load_now) begin
         new_pend_r <= 1'b0;
      end
   end

   // Output register keeps the previous result until the load is allowed
   always_ff @(posedge clk) begin
      if (rst) begin
         out_reg_r <= '0;
      end else if (load_now) begin
         out_reg_r <= conv_code_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         armed_r <= 1'b0;
         bit_cnt_r <= `BIT_CNT_ZERO;
         shift_r <= '0;
      end else if (cs_rise) begin
         armed_r <= 1'b1;
         bit_cnt_r <= `BIT_CNT_ZERO;
      end else if (armed_r && sck_rise && bit_cnt_r < `BITS_PER_READ) begin
         // Independent of power state, so reads work while powered down
         if (bit_cnt_r == `BIT_CNT_ZERO) begin
            shift_r <= {out_reg_r[`RES_W-2:0], 1'b0};
         end else begin
            shift_r <= {shift_r[`RES_W-2:0], 1'b0};
         end
         bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (armed_r && sck_fall && bit_cnt_r == `BITS_PER_READ) begin
         armed_r <= 1'b0;
         bit_cnt_r <= `BIT_CNT_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dout_o <= 1'b0;
         dout_oe <= 1'b0;
      end else if (cs_rise) begin
         dout_oe <= 1'b0;
      end else if (armed_r && sck_rise && bit_cnt_r < `BITS_PER_READ) begin
         dout_oe <= 1'b1;
         dout_o <= (bit_cnt_r == `BIT_CNT_ZERO) ? out_reg_r[`LAST_BIT_IDX]
                                                 : shift_r[`LAST_BIT_IDX];
      end else if (armed_r && sck_fall && bit_cnt_r == `BITS_PER_READ) begin
         dout_oe <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   reset_down_a: assert property (@(posedge clk) $fell(rst) |-> !powered)
      else $error("not powered down after reset");
   wake_a: assert property (@(posedge clk) disable iff (rst)
      (state_r == PWR_DOWN && cs_rise) |=> state_r == PWR_UP)
      else $error("no wake on rising edge");
   start_a: assert property (@(posedge clk) disable iff (rst)
      (state_r == IDLE && cs_fall) |=> state_r == CONVERT && tmr_r == '0)
      else $error("no conversion on falling edge");
   mode_pick_a: assert property (@(posedge clk) disable iff (rst)
      conv_done |=> state_r == ($past(cs_level) ? IDLE : PWR_DOWN))
      else $error("wrong mode after conversion");
   auto_down_a: assert property (@(posedge clk) disable iff (rst)
      (conv_done && !cs_level) |-> ##2 !powered)
      else $error("no power down");
   pend_hold_a: assert property (@(posedge clk) disable iff (rst)
      (new_pend_r && reading && !cs_rise) |=> $stable(out_reg_r))
      else $error("result loaded during read");
   cnt_clear_a: assert property (@(posedge clk) disable iff (rst)
      cs_rise |=> bit_cnt_r == `BIT_CNT_ZERO && armed_r)
      else $error("counter not cleared");
   no_data_a: assert property (@(posedge clk) disable iff (rst)
      (!armed_r && !cs_rise) |=> !$rose(dout_oe))
      else $error("data out while not armed");
   hiz_a: assert property (@(posedge clk) disable iff (rst)
      (armed_r && sck_fall && bit_cnt_r == `BITS_PER_READ && !cs_rise) |=> !dout_oe)
      else $error("output not released");
   msb_first_a: assert property (@(posedge clk) disable iff (rst)
      (armed_r && sck_rise && bit_cnt_r == `BIT_CNT_ZERO && !cs_rise)
      |=> dout_o == $past(out_reg_r[`LAST_BIT_IDX]))
      else $error("first bit not msb");
endmodule

// ===== rtl/adc_ctrl_consts.svh
// Timing and field constants for the converter control block
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

`define CLK_MHZ 125
`define T_CONV_TYP_NS 4000
`define T_PWRUP_NS 1500
`define CONV_CYC ((`T_CONV_TYP_NS * `CLK_MHZ) / 1000)
`define PWRUP_CYC (((`T_PWRUP_NS * `CLK_MHZ) + 999) / 1000)
`define CNT_W 10
`define RES_W 8
`define BITS_PER_READ 4'h8
`define BIT_CNT_ZERO 4'h0
`define LAST_BIT_IDX 3'h7

`endif

// ===== rtl/adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;
   typedef enum logic [1:0] {
      PWR_DOWN,
      PWR_UP,
      IDLE,
      CONVERT
   } conv_state_t;
endpackage

// ===== rtl/pin_sync.sv
// Two flip-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module pin_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
endmodule

// ===== test/mcu_model.sv
// Microcontroller model driving convert start and serial clock, reading data
`timescale 1ns/1ps
module mcu_model (
   input wire logic clk,
   input wire logic dout_o,
   input wire logic dout_oe,
   output logic conv_start_n,
   output logic sclk
);
   // Pin held low through reset; serial clock stands low outside frames
   initial begin
      conv_start_n = 1'b0;
      sclk = 1'b0;
   end

   task automatic set_cs(input logic v);
      @(posedge clk);
      #1 conv_start_n = v;
   endtask

   // ----------------------------------------
   // Eight-bit read, 160 ns serial clock
   // ----------------------------------------
   // The pin is never moved mid-read
   task automatic read_byte(output logic [7:0] d, output logic any_oe);
      d = 8'h00;
      any_oe = 1'b0;
      for (int i = 0; i < 8; i++) begin
         repeat (10) @(posedge clk);
         #1 sclk = 1'b1;
         repeat (10) @(posedge clk);
         // Released line reads as the inverse of the last bit, not a stale value
         #1 d = {d[6:0], (dout_oe === 1'b1) ? dout_o : ~d[0]};
         any_oe = any_oe | (dout_oe === 1'b1);
         sclk = 1'b0;
      end
      repeat (10) @(posedge clk);
      // Return off the edge so the caller's next stimulus keeps the same small delay
      #1;
   endtask
endmodule

// ===== test/sar_adc_conv_serial_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_conv_serial_ctrl_tb;
   import adc_ctrl_pkg::*;
   logic clk;
   logic rst;
   logic [7:0] sample_code;
   logic conv_start_n;
   logic sclk;
   logic dout_o;
   logic dout_oe;
   logic powered;
   logic tracking;
   logic conv_busy;
   logic sample_hold;
   int num_errors;
   int comparisons;
   int cycles;
   logic [7:0] d;
   logic oe;
   int n;

   mcu_model mcu (.clk(clk), .dout_o(dout_o), .dout_oe(dout_oe),
      .conv_start_n(conv_start_n), .sclk(sclk));
   sar_adc_conv_serial_ctrl uut (.clk(clk), .rst(rst), .conv_start_n(conv_start_n),
      .sclk(sclk), .sample_code(sample_code), .dout_o(dout_o), .dout_oe(dout_oe),
      .powered(powered), .tracking(tracking), .conv_busy(conv_busy),
      .sample_hold(sample_hold));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic conclude();
      if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Whole run needs about 2800 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         num_errors++;
         $display("MISMATCH %0t timeout", $time);
         conclude();
      end
   end

   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   task automatic wait_busy(input logic v, input int max, output int cnt);
      cnt = 0;
      // Look after the edge has settled, never in the time step that launches the flag
      while (conv_busy !== v && cnt < max) begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask

   task automatic t_reset();
      check(powered === 1'b0 && dout_oe === 1'b0, "not powered down after reset");
      mcu.read_byte(d, oe);
      check(oe === 1'b0, "data driven before any arming edge");
   endtask

   // ----------------------------------------
   // Power-down mode with a short pulse
   // ----------------------------------------
   task automatic t_mode2();
      sample_code = 8'ha5;
      mcu.set_cs(1'b1);
      repeat (6) @(posedge clk);
      #1 check(powered === 1'b1, "no wake on rising edge");
      mcu.set_cs(1'b0);
      wait_busy(1'b1, 400, n);
      check(n >= 175 && n <= 200, "conversion did not wait out power-up");
      check(sample_hold === 1'b1 && tracking === 1'b0, "sample not held");
      sample_code = 8'h00;
      wait_busy(1'b0, 600, n);
      check(n >= 495 && n <= 505, "conversion length wrong");
      repeat (5) @(posedge clk);
      #1 check(powered === 1'b0, "no power-down with pin low");
   endtask

   task automatic t_read_pd();
      // Conversion already over, so the current result is due
      mcu.set_cs(1'b1);
      mcu.read_byte(d, oe);
      check(d === 8'ha5, "wrong read after conversion");
      check(dout_oe === 1'b0, "output still driven after eighth bit");
      mcu.read_byte(d, oe);
      check(oe === 1'b0, "clock not ignored after eight bits");
   endtask

   // ----------------------------------------
   // High-speed mode, reads before and across end
   // ----------------------------------------
   task automatic t_mode1();
      sample_code = 8'h3c;
      mcu.set_cs(1'b0);
      repeat (10) @(posedge clk);
      mcu.set_cs(1'b1);
      mcu.read_byte(d, oe);
      check(d === 8'ha5, "early read not the previous result");
      wait_busy(1'b0, 600, n);
      repeat (5) @(posedge clk);
      #1 check(powered === 1'b1 && tracking === 1'b1, "powered down with pin high");
      sample_code = 8'h81;
      mcu.set_cs(1'b0);
      repeat (10) @(posedge clk);
      mcu.set_cs(1'b1);
      repeat (400) @(posedge clk);
      mcu.read_byte(d, oe);
      check(d === 8'h3c, "read across conversion end corrupted");
      mcu.set_cs(1'b0);
      repeat (10) @(posedge clk);
      mcu.set_cs(1'b1);
      mcu.read_byte(d, oe);
      check(d === 8'h81, "deferred result not loaded");
      wait_busy(1'b0, 600, n);
   endtask

   initial begin
      num_errors = 0;
      comparisons = 0;
      cycles = 0;
      rst = 1'b1;
      sample_code = 8'h00;
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      repeat (2) @(posedge clk);
      #1 t_reset();
      t_mode2();
      t_read_pd();
      t_mode1();
      conclude();
   end
endmodule
